// [rtl/rcrt_ost.sv]
// Oscillator start-up counter: counts oscillator periods before clock release
`timescale 1ns/10ps
module rcrt_ost #(
    parameter int WIDTH = rcrt_pkg::OST_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_srst,
    rcrt_ost_if.cnt ost
);
    logic [WIDTH-1:0] cnt_q;
    logic run_q;
    logic done_q;

    assign ost.done = done_q;

    always_ff @(posedge i_clk) begin
        if (i_srst || ost.start) begin
            cnt_q <= '0;
            run_q <= ost.start;
            done_q <= 1'b0;
        end else if (run_q && ost.osc_tick) begin
            cnt_q <= cnt_q + 1'b1;
            if (&cnt_q) begin
                run_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end
endmodule : rcrt_ost

// [rtl/rcrt_ost_if.sv]
// Interface: oscillator start-up counter request and done
`timescale 1ns/10ps
interface rcrt_ost_if;
    logic start;
    logic osc_tick;
    logic done;
    modport ctrl (output start, output osc_tick, input done);
    modport cnt (input start, input osc_tick, output done);
endinterface : rcrt_ost_if

// [rtl/rcrt_pkg.sv]
// Package: register map, flag positions and timing constants of the reset sequencer
package rcrt_pkg;
    // APB register byte addresses
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // Cause flag positions
    localparam int BIT_POR = 0;
    localparam int BIT_BOR = 1;
    localparam int BIT_IDLE = 2;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int BIT_SWR = 6;
    localparam int BIT_PIN = 7;
    localparam int BIT_DEEP = 10;
    localparam int BIT_ILLOP = 14;
    localparam int BIT_TRAP = 15;
    localparam logic [15:0] CAUSE_POR_VALUE = 16'h0003;
    localparam logic [15:0] CAUSE_BOR_VALUE = 16'h0002;
    // Control register fields
    localparam int CTRL_PWRT_EN = 0;
    localparam int CTRL_TWO_SPEED = 1;
    localparam int CTRL_OSC_CRYSTAL = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int POR_DELAY_NS = 10_000;
    localparam int PWRT_DELAY_MS = 64;
    localparam int POR_DELAY_CYC = (POR_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int PWRT_DELAY_CYC = PWRT_DELAY_MS * (CLK_HZ / 1000);
    localparam int OST_PERIODS = 1024;
    localparam int OST_WIDTH = 10;
    localparam logic [23:0] RESET_VECTOR = 24'h000000;
    localparam logic [23:0] PC_STEP = 24'h000002;
endpackage : rcrt_pkg

// [rtl/rcrt_top.sv]
// Reset cause flags and master reset release sequencer
// Operation
// - Power-on clears all cause flags but sets brown-out and power-on; PC zero
// - Pin reset in run sets bit 7 only; restart at zero
// - Pin reset in idle, sleep, deep sleep also keeps bit 2, 3 or 10
// - Watchdog sets bit 4; run restarts at zero, idle continues at PC+2
// - Illegal opcode or uninitialised register sets bit 14; cleared by power-on or a software write
// - Wake by interrupt: PC+2 if priority not above CPU level, else vector
// - Software may write each flag either way; writes never cause reset
// - After power-on hold reset for power-on delay then optional power-up timer
// - Power-up timer lasts 64 ms when enabled, none when disabled
// - After brown-out release when power-up timer expires, no power-on delay
// - Other sources release reset at once when removed
// - No execution until oscillator delivers a valid clock
// - Crystal oscillators wait 1024 periods on a 10-bit counter
// - Oscillator start-up and PLL lock run alongside reset delays
// - Two-speed start-up comes out of reset on the fast RC clock
// - Any source asserts master reset, watchdog only in run mode; software reset releases next cycle, sets flag
`timescale 1ns/10ps
module rcrt_top #(
    parameter int POR_CYC = rcrt_pkg::POR_DELAY_CYC,
    parameter int PWRT_CYC = rcrt_pkg::PWRT_DELAY_CYC
) (
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_RESET_PIN_N,
    input wire logic I_BROWNOUT,
    input wire logic I_WDT_TIMEOUT,
    input wire logic I_SW_RESET,
    input wire logic I_TRAP_CONFLICT,
    input wire logic I_ILLEGAL_OP,
    input wire logic I_STACK_FAULT,
    input wire logic I_ENTER_IDLE,
    input wire logic I_ENTER_SLEEP,
    input wire logic I_DEEP_ENABLE,
    input wire logic I_WDT_CLEAR,
    input wire logic I_IRQ_WAKE,
    input wire logic [2:0] I_IRQ_PRIO,
    input wire logic [2:0] I_CPU_PRIO,
    input wire logic [23:0] I_PC,
    input wire logic [23:0] I_IRQ_VECTOR,
    input wire logic I_OSC_TICK,
    input wire logic I_PLL_LOCKED,
    input wire logic I_USE_PLL,
    output logic O_MASTER_SYSTEM_RESET,
    output logic O_RUN_ENABLE,
    output logic O_SEL_FAST_RC,
    output logic O_PC_LOAD,
    output logic [23:0] O_PC_VALUE
);
    typedef enum logic [1:0] {
        RCRT_ST_IDLE = 2'b00,
        RCRT_ST_POR = 2'b01,
        RCRT_ST_PWRT = 2'b10,
        RCRT_ST_HOLD = 2'b11
    } rcrt_state_t;

    typedef enum logic [1:0] {
        RCRT_MD_RUN = 2'b00,
        RCRT_MD_IDLE = 2'b01,
        RCRT_MD_SLEEP = 2'b10,
        RCRT_MD_DEEP = 2'b11
    } rcrt_mode_t;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pin_n_s1_q;
    logic [1:0] bor_s1_q;
    logic pin_act;
    logic bor_act;
    logic pin_act_q;
    logic bor_act_q;

    always_ff @(posedge I_CLK_SYS) begin
        pin_n_s1_q <= {pin_n_s1_q[0], I_RESET_PIN_N};
        bor_s1_q <= {bor_s1_q[0], I_BROWNOUT};
    end
    assign pin_act = ~pin_n_s1_q[1];
    assign bor_act = bor_s1_q[1];
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            pin_act_q <= 1'b0;
            bor_act_q <= 1'b0;
        end else begin
            pin_act_q <= pin_act;
            bor_act_q <= bor_act;
        end
    end

    // ------------------------------------------------------------
    // Control register and release timing
    // ------------------------------------------------------------
    logic [2:0] ctrl_q;
    rcrt_state_t state_q;
    logic [31:0] dly_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic rst_src;
    logic pwrt_en;
    logic mrst_q;
    rcrt_mode_t mode_q;

    assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd_en = I_PSEL && !I_PENABLE && !I_PWRITE;
    assign addr_ok = (I_PADDR == rcrt_pkg::ADDR_CAUSE) || (I_PADDR == rcrt_pkg::ADDR_CTRL)
        || (I_PADDR == rcrt_pkg::ADDR_STATUS);
    assign pwrt_en = ctrl_q[rcrt_pkg::CTRL_PWRT_EN];
    // Any active source, including the synchronised pin and brown-out; watchdog only in run mode
    assign rst_src = pin_act || bor_act || (I_WDT_TIMEOUT && mode_q == RCRT_MD_RUN)
        || I_SW_RESET || I_TRAP_CONFLICT || I_ILLEGAL_OP || I_STACK_FAULT;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            ctrl_q <= rcrt_pkg::CTRL_RESET;
        end else if (wr_en && I_PADDR == rcrt_pkg::ADDR_CTRL) begin
            ctrl_q <= I_PWDATA[2:0];
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            state_q <= RCRT_ST_POR;
            dly_q <= '0;
            mrst_q <= 1'b1;
        end else begin
            case (state_q)
                RCRT_ST_POR: begin
                    mrst_q <= 1'b1;
                    if (dly_q >= 32'(POR_CYC - 1)) begin
                        dly_q <= '0;
                        state_q <= pwrt_en ? RCRT_ST_PWRT : RCRT_ST_HOLD;
                    end else begin
                        dly_q <= dly_q + 32'd1;
                    end
                end
                RCRT_ST_PWRT: begin
                    mrst_q <= 1'b1;
                    if (bor_act) begin
                        dly_q <= '0;
                    end else if (dly_q >= 32'(PWRT_CYC - 1)) begin
                        dly_q <= '0;
                        state_q <= RCRT_ST_HOLD;
                    end else begin
                        dly_q <= dly_q + 32'd1;
                    end
                end
                RCRT_ST_HOLD: begin
                    // Wait for the source to go away
                    mrst_q <= 1'b1;
                    if (bor_act) begin
                        mrst_q <= 1'b1;
                    end else if (bor_act_q && pwrt_en) begin
                        state_q <= RCRT_ST_PWRT;
                    end else if (!rst_src) begin
                        mrst_q <= 1'b0;
                        state_q <= RCRT_ST_IDLE;
                    end
                end
                RCRT_ST_IDLE: begin
                    if (rst_src) begin
                        mrst_q <= 1'b1;
                        state_q <= RCRT_ST_HOLD;
                    end else begin
                        mrst_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= RCRT_ST_POR;
                    mrst_q <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Power mode tracking
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST || (mrst_q && state_q != RCRT_ST_IDLE && !rst_src)) begin
            mode_q <= RCRT_MD_RUN;
        end else if (I_ENTER_SLEEP) begin
            mode_q <= I_DEEP_ENABLE ? RCRT_MD_DEEP : RCRT_MD_SLEEP;
        end else if (I_ENTER_IDLE) begin
            mode_q <= RCRT_MD_IDLE;
        end else if (I_IRQ_WAKE || (I_WDT_TIMEOUT && mode_q != RCRT_MD_RUN)) begin
            mode_q <= RCRT_MD_RUN;
        end
    end

    // ------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------
    logic [15:0] cause_q;
    logic [15:0] cause_d;
    logic pin_rise;

    assign pin_rise = pin_act && !pin_act_q;

    always_comb begin
        cause_d = cause_q;
        if (wr_en && I_PADDR == rcrt_pkg::ADDR_CAUSE) begin
            cause_d = I_PWDATA[15:0];
        end
        if (I_WDT_CLEAR) begin
            cause_d[rcrt_pkg::BIT_IDLE] = 1'b0;
            cause_d[rcrt_pkg::BIT_SLEEP] = 1'b0;
        end
        // Hardware sets win over a same-cycle software or watchdog clear
        if (I_ENTER_SLEEP && I_DEEP_ENABLE) begin
            cause_d[rcrt_pkg::BIT_DEEP] = 1'b1;
            cause_d[rcrt_pkg::BIT_BOR] = 1'b1;
            cause_d[rcrt_pkg::BIT_POR] = 1'b1;
        end else if (I_ENTER_SLEEP) begin
            cause_d[rcrt_pkg::BIT_SLEEP] = 1'b1;
            cause_d[rcrt_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end else if (I_ENTER_IDLE) begin
            cause_d[rcrt_pkg::BIT_IDLE] = 1'b1;
            cause_d[rcrt_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
        if (pin_rise) begin
            cause_d[rcrt_pkg::BIT_PIN] = 1'b1;
        end
        if (I_SW_RESET) begin
            cause_d[rcrt_pkg::BIT_SWR] = 1'b1;
        end
        if (I_WDT_TIMEOUT) begin
            cause_d[rcrt_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        end
        if (I_ILLEGAL_OP) begin
            cause_d[rcrt_pkg::BIT_ILLOP] = 1'b1;
        end
        if (I_TRAP_CONFLICT) begin
            cause_d[rcrt_pkg::BIT_TRAP] = 1'b1;
        end
        if (bor_act) begin
            cause_d[rcrt_pkg::BIT_BOR] = 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            cause_q <= rcrt_pkg::CAUSE_POR_VALUE;
        end else begin
            cause_q <= cause_d;
        end
    end

    // ------------------------------------------------------------
    // Oscillator start-up and execution gate
    // ------------------------------------------------------------
    rcrt_ost_if ost ();
    logic ost_start_q;
    logic clk_valid;
    logic run_q;

    assign ost.start = ost_start_q;
    assign ost.osc_tick = I_OSC_TICK;

    // Counter launched at power-on so it runs alongside the reset delays
    always_ff @(posedge I_CLK_SYS) begin
        ost_start_q <= I_SRST;
    end

    rcrt_ost u_ost (
        .i_clk(I_CLK_SYS),
        .i_srst(I_SRST),
        .ost(ost)
    );

    always_comb begin
        clk_valid = 1'b1;
        if (ctrl_q[rcrt_pkg::CTRL_TWO_SPEED]) begin
            clk_valid = 1'b1;
        end else begin
            if (ctrl_q[rcrt_pkg::CTRL_OSC_CRYSTAL] && !ost.done) begin
                clk_valid = 1'b0;
            end
            if (I_USE_PLL && !I_PLL_LOCKED) begin
                clk_valid = 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            run_q <= 1'b0;
            O_SEL_FAST_RC <= 1'b0;
        end else begin
            run_q <= !mrst_q && !rst_src && clk_valid;
            O_SEL_FAST_RC <= ctrl_q[rcrt_pkg::CTRL_TWO_SPEED] && (mrst_q || !ost.done);
        end
    end

    assign O_MASTER_SYSTEM_RESET = mrst_q;
    assign O_RUN_ENABLE = run_q;

    // ------------------------------------------------------------
    // Program counter selection
    // ------------------------------------------------------------
    logic mrst_prev_q;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            mrst_prev_q <= 1'b1;
            O_PC_LOAD <= 1'b1;
            O_PC_VALUE <= rcrt_pkg::RESET_VECTOR;
        end else begin
            mrst_prev_q <= mrst_q;
            O_PC_LOAD <= 1'b0;
            if (mrst_q && !mrst_prev_q) begin
                O_PC_LOAD <= 1'b1;
                O_PC_VALUE <= rcrt_pkg::RESET_VECTOR;
            end else if (I_WDT_TIMEOUT && mode_q != RCRT_MD_RUN) begin
                O_PC_LOAD <= 1'b1;
                O_PC_VALUE <= I_PC + rcrt_pkg::PC_STEP;
            end else if (I_IRQ_WAKE && mode_q != RCRT_MD_RUN) begin
                O_PC_LOAD <= 1'b1;
                O_PC_VALUE <= (I_IRQ_PRIO <= I_CPU_PRIO) ? I_PC + rcrt_pkg::PC_STEP : I_IRQ_VECTOR;
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_PRDATA <= '0;
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= I_PSEL && !I_PENABLE;
            O_PSLVERR <= I_PSEL && !I_PENABLE && !addr_ok;
            if (rd_en) begin
                case (I_PADDR)
                    rcrt_pkg::ADDR_CAUSE: O_PRDATA <= {16'h0000, cause_q};
                    rcrt_pkg::ADDR_CTRL: O_PRDATA <= {29'h0, ctrl_q};
                    rcrt_pkg::ADDR_STATUS: O_PRDATA <= {26'h0, mode_q, state_q, run_q, mrst_q};
                    default: O_PRDATA <= '0;
                endcase
            end
        end
    end
endmodule : rcrt_top

// [tb/rcrt_asserts.sv]
// Concurrent checks on the reset sequencer top ports
`timescale 1ns/10ps
module rcrt_asserts #(
    parameter int POR_CYC = 100,
    parameter int PWRT_CYC = 50
) (
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_RESET_PIN_N,
    input wire logic I_ILLEGAL_OP,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_MASTER_SYSTEM_RESET,
    input wire logic O_RUN_ENABLE,
    input wire logic O_PC_LOAD,
    input wire logic [23:0] O_PC_VALUE
);
    // ----------------------------
    // Power-on hold counter
    // ----------------------------
    logic por_q;
    int cnt_q;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            por_q <= 1'b1;
            cnt_q <= 0;
        end else if (!O_MASTER_SYSTEM_RESET) begin
            por_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);
    mrst_on_por_a: assert property ($fell(I_SRST) |-> O_MASTER_SYSTEM_RESET ##1 O_MASTER_SYSTEM_RESET)
        else $error("master reset not held after power-on");
    por_hold_a: assert property (por_q && !O_MASTER_SYSTEM_RESET |-> cnt_q >= POR_CYC + PWRT_CYC - 2)
        else $error("power-on release too early");
    pc_zero_a: assert property ($fell(I_SRST) |-> O_PC_LOAD && O_PC_VALUE == 24'h000000)
        else $error("power-on vector not zero");
    no_run_rst_a: assert property (O_MASTER_SYSTEM_RESET |-> !O_RUN_ENABLE)
        else $error("run enabled during master reset");
    pin_rst_a: assert property (!I_RESET_PIN_N |-> ##[1:4] O_MASTER_SYSTEM_RESET)
        else $error("pin reset not applied");
    illop_rst_a: assert property (I_ILLEGAL_OP |-> ##[1:3] O_MASTER_SYSTEM_RESET)
        else $error("illegal operation reset missing");
    apb_ready_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
        else $error("no ready in access cycle");
    slverr_ready_a: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error without ready");
endmodule : rcrt_asserts

// [tb/rcrt_osc_model.sv]
// Oscillator and PLL model on the far side of the sequencer
`timescale 1ns/10ps
module rcrt_osc_model #(
    parameter int LOCK_CYC = 300
) (
    input wire logic i_clk,
    input wire logic i_srst,
    output logic o_osc_tick,
    output logic o_pll_locked
);
    int cnt_q;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_q <= 0;
            o_osc_tick <= 1'b0;
            o_pll_locked <= 1'b0;
        end else begin
            o_osc_tick <= ~o_osc_tick;
            cnt_q <= (cnt_q < LOCK_CYC) ? cnt_q + 1 : cnt_q;
            o_pll_locked <= (cnt_q >= LOCK_CYC - 1);
        end
    end
endmodule : rcrt_osc_model

// [tb/tb.sv]
// Testbench: reset cause flags and release timing over APB
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    localparam int POR = 20;
    localparam int PWRT = 50;
    logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, pin_n = 1, bo = 0, wdt = 0, software_reset_flag = 0;
    logic trap = 0, illop = 0, stk = 0, idle = 0, slp = 0, deep = 0, wclr = 0, wake = 0;
    logic tick, lock, mrst, run, fast_internal_rc_clock, pcl, pready, pslverr, use_pll = 1;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [2:0] iprio = 0, cprio = 0;
    logic [23:0] pc = 0, vec = 24'h000400, pcv, last_pc;
    int num_errors = 0, samples_checked = 0, pc_cnt = 0, cyc = 0;
    rcrt_top #(.POR_CYC(POR), .PWRT_CYC(PWRT)) rcrt_top_i (.I_CLK_SYS(clk), .I_SRST(srst),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RESET_PIN_N(pin_n),
        .I_BROWNOUT(bo), .I_WDT_TIMEOUT(wdt), .I_SW_RESET(software_reset_flag), .I_TRAP_CONFLICT(trap),
        .I_ILLEGAL_OP(illop), .I_STACK_FAULT(stk), .I_ENTER_IDLE(idle), .I_ENTER_SLEEP(slp),
        .I_DEEP_ENABLE(deep), .I_WDT_CLEAR(wclr), .I_IRQ_WAKE(wake), .I_IRQ_PRIO(iprio),
        .I_CPU_PRIO(cprio), .I_PC(pc), .I_IRQ_VECTOR(vec), .I_OSC_TICK(tick), .I_PLL_LOCKED(lock),
        .I_USE_PLL(use_pll), .O_MASTER_SYSTEM_RESET(mrst), .O_RUN_ENABLE(run),
        .O_SEL_FAST_RC(fast_internal_rc_clock), .O_PC_LOAD(pcl), .O_PC_VALUE(pcv));
    rcrt_osc_model #(.LOCK_CYC(300)) rcrt_osc_model_i (.i_clk(clk), .i_srst(srst),
        .o_osc_tick(tick), .o_pll_locked(lock));
    // ----------------------------
    // Clock, monitor, watchdog
    // ----------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= srst ? 0 : cyc + 1;
        if (pcl === 1'b1) begin
            last_pc <= pcv;
            pc_cnt <= pc_cnt + 1;
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    // ----------------------------
    // Tasks
    // ----------------------------
    task automatic end_sim();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rc(input logic [15:0] x, input logic [15:0] m);
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h00, 32'h0, r, e);
        `CHK(r[15:0] & m, x)
    endtask : rc
    task automatic wrel(output int n);
        int k;
        k = 0;
        n = 0;
        while (mrst !== 1'b1 && k < 10) begin
            @(posedge clk);
            k++;
        end
        `CHK(k < 10, 1'b1)
        while (mrst !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
    endtask : wrel
    task automatic pin_rst(output int n);
        @(posedge clk);
        pin_n <= 0;
        repeat (5) @(posedge clk);
        pin_n <= 1;
        wrel(n);
    endtask : pin_rst
    task automatic wpc(input logic [23:0] x);
        int c;
        int k;
        c = pc_cnt;
        k = 0;
        while (pc_cnt == c && k < 20) begin
            @(posedge clk);
            k++;
        end
        `CHK(k < 20, 1'b1)
        @(posedge clk);
        `CHK(last_pc, x)
    endtask : wpc
    // ----------------------------
    // Scenarios
    // ----------------------------
    initial begin
        int n, m;
        logic [31:0] r;
        logic e;
        repeat (4) @(posedge clk);
        srst <= 0;
        wrel(n);
        `CHK(n >= POR + PWRT - 1 && n < POR + PWRT + 5, 1'b1)
        `CHK(run, 1'b0)
        for (m = 0; run !== 1'b1 && m < 400; m++) @(posedge clk);
        `CHK(n + m >= 298 && n + m < 306, 1'b1)
        rc(16'h0003, 16'hffff);
        wr(8'h00, 32'h0000_4080);
        rc(16'h4080, 16'hffff);
        `CHK(mrst, 1'b0)
        apb(1'b0, 8'h0c, 32'h0, r, e);
        `CHK({e, r}, 33'h1_0000_0000)
        wr(8'h00, 32'h0);
        m = pc_cnt;
        pin_rst(n);
        `CHK(n < 10, 1'b1)
        rc(16'h0080, 16'hffff);
        `CHK(last_pc, 24'h000000)
        `CHK(pc_cnt - m, 1)
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 32'h0);
            deep <= (i == 2);
            @(posedge clk);
            idle <= (i == 0);
            slp <= (i > 0);
            @(posedge clk);
            {deep, idle, slp} <= 3'h0;
            pin_rst(n);
            rc(i == 0 ? 16'h0084 : i == 1 ? 16'h0088 : 16'h0480, 16'hfffc);
        end
        wr(8'h00, 32'h0);
        m = pc_cnt;
        wdt <= 1;
        @(posedge clk);
        wdt <= 0;
        wrel(n);
        rc(16'h0010, 16'hffff);
        `CHK(last_pc, 24'h000000)
        `CHK(pc_cnt - m, 1)
        wr(8'h00, 32'h0);
        pc <= 24'h000100;
        idle <= 1;
        @(posedge clk);
        idle <= 0;
        @(posedge clk);
        wdt <= 1;
        @(posedge clk);
        wdt <= 0;
        wpc(24'h000102);
        rc(16'h0014, 16'hffff);
        `CHK(mrst, 1'b0)
        pc <= 24'h000200;
        for (int j = 0; j < 2; j++) begin
            idle <= (j == 0);
            slp <= (j == 1);
            cprio <= 3'h3;
            iprio <= (j == 0) ? 3'h3 : 3'h4;
            @(posedge clk);
            {idle, slp} <= 2'h0;
            wake <= 1;
            @(posedge clk);
            wake <= 0;
            wpc(j == 0 ? 24'h000202 : 24'h000400);
        end
        wr(8'h00, 32'h0);
        illop <= 1;
        @(posedge clk);
        illop <= 0;
        wrel(n);
        pin_rst(n);
        rc(16'h4080, 16'hffff);
        for (int p = 1; p >= 0; p--) begin
            wr(8'h04, p);
            wr(8'h00, 32'h0);
            bo <= 1;
            repeat (5) @(posedge clk);
            bo <= 0;
            wrel(n);
            `CHK(p ? (n >= PWRT - 1 && n < PWRT + 8) : (n < 8), 1'b1)
            rc(16'h0002, 16'hffff);
        end
        wr(8'h00, 32'h0);
        software_reset_flag <= 1;
        @(posedge clk);
        software_reset_flag <= 0;
        wrel(n);
        `CHK(n < 5, 1'b1)
        rc(16'h0040, 16'hffff);
        // Two-speed start keeps running on the fast clock while the crystal count is open
        wr(8'h04, 32'h6);
        repeat (2) @(posedge clk);
        `CHK({fast_internal_rc_clock, run}, 2'b11)
        wr(8'h04, 32'h4);
        repeat (2) @(posedge clk);
        `CHK(run, 1'b0)
        while (run !== 1'b1) @(posedge clk);
        `CHK(cyc >= 2048 && cyc < 2056, 1'b1)
        wr(8'h04, 32'h6);
        repeat (2) @(posedge clk);
        `CHK({fast_internal_rc_clock, run}, 2'b01)
        end_sim();
    end
endmodule : tb
bind rcrt_top rcrt_asserts #(.POR_CYC(POR_CYC), .PWRT_CYC(PWRT_CYC)) rcrt_asserts_i (.I_CLK_SYS(I_CLK_SYS),
    .I_SRST(I_SRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_RESET_PIN_N(I_RESET_PIN_N),
    .I_ILLEGAL_OP(I_ILLEGAL_OP), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_MASTER_SYSTEM_RESET(O_MASTER_SYSTEM_RESET), .O_RUN_ENABLE(O_RUN_ENABLE),
    .O_PC_LOAD(O_PC_LOAD), .O_PC_VALUE(O_PC_VALUE));
